// *** bench/slls_far_model.sv ***
// far side lane receiver outputs seen by the status bank, set lane by lane
`timescale 1ns/1ns
module slls_far_model
	import slls_pkg::*;
(
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic cmd_stb,
	input wire logic cmd_lane,
	input wire logic [23:0] cmd_cnts,
	input wire logic [SLLS_SYNC_W-1:0] cmd_locks,
	output logic [1:0][SLLS_CNT_W-1:0] disp_cnt_ff,
	output logic [1:0][SLLS_CNT_W-1:0] sym_cnt_ff,
	output logic [1:0][SLLS_CNT_W-1:0] ctrl_cnt_ff,
	output logic [1:0][SLLS_SYNC_W-1:0] locks_ff
);
	// levels change only after an edge, like a real receiver on the same clock
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			disp_cnt_ff <= '0;
			sym_cnt_ff <= '0;
			ctrl_cnt_ff <= '0;
			locks_ff <= '0;
		end else if (cmd_stb) begin
			{disp_cnt_ff[cmd_lane], sym_cnt_ff[cmd_lane], ctrl_cnt_ff[cmd_lane]} <= cmd_cnts;
			locks_ff[cmd_lane] <= cmd_locks;
		end
	end
endmodule

// *** bench/slls_link_status_bench.sv ***
// self-checking bench for the lane 2 and 3 link health bank
`timescale 1ns/1ns
`define CHK(what, exp, got) begin cmp_count++; if ((got) !== (exp)) begin mismatches++; \
	$display("unexpected %s expected %h seen %h", what, exp, got); end end
module slls_link_status_bench;
	import slls_pkg::*;
	typedef struct {logic lane; logic [23:0] cnts; logic [4:0] locks; logic [7:0] flags;} slls_row_t;
	logic clk_sys = 1'b0;
	logic sys_rst = 1'b1;
	logic [SLLS_ADDR_W-1:0] reg_addr = '0;
	logic [SLLS_DATA_W-1:0] reg_wdata = '0;
	logic reg_wr_stb = 1'b0;
	logic reg_rd_stb = 1'b0;
	logic [SLLS_DATA_W-1:0] reg_rdata_ff;
	logic cmd_stb = 1'b0;
	logic cmd_lane = 1'b0;
	logic [23:0] cmd_cnts = '0;
	logic [4:0] cmd_locks = '0;
	logic [1:0][7:0] disp_cnt, sym_cnt, ctrl_cnt;
	logic [1:0][4:0] locks;
	logic [7:0] error_threshold_ff;
	logic skip_align_sequence_ff;
	logic irq;
	logic [7:0] rd;
	int mismatches = 0;
	int cmp_count = 0;
	// threshold 8'h20: one below, at and above it, lock bits in all-off, all-on, single and alternating patterns
	slls_row_t rows [6] = '{
		'{1'b0, 24'h1f_1f1f, 5'h00, 8'h00},
		'{1'b0, 24'h20_0000, 5'h1f, 8'h9f},
		'{1'b0, 24'h00_2000, 5'h10, 8'h50},
		'{1'b0, 24'h00_00ff, 5'h01, 8'h21},
		'{1'b1, 24'h21_2121, 5'h0a, 8'hea},
		'{1'b1, 24'h1f_201f, 5'h15, 8'h55}};

	always #25 clk_sys = ~clk_sys;

	slls_far_model i_slls_far_model (.clk_sys(clk_sys), .sys_rst(sys_rst), .cmd_stb(cmd_stb),
		.cmd_lane(cmd_lane), .cmd_cnts(cmd_cnts), .cmd_locks(cmd_locks), .disp_cnt_ff(disp_cnt),
		.sym_cnt_ff(sym_cnt), .ctrl_cnt_ff(ctrl_cnt), .locks_ff(locks));

	slls_link_status i_slls_link_status (.clk_sys(clk_sys), .sys_rst(sys_rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr_stb(reg_wr_stb), .reg_rd_stb(reg_rd_stb),
		.reg_rdata_ff(reg_rdata_ff), .disp_cnt(disp_cnt), .sym_cnt(sym_cnt), .ctrl_cnt(ctrl_cnt),
		.deskew_done({locks[1][4], locks[0][4]}), .initial_align_ok({locks[1][3], locks[0][3]}),
		.config_checksum_ok({locks[1][2], locks[0][2]}), .frame_lock({locks[1][1], locks[0][1]}),
		.codegroup_lock({locks[1][0], locks[0][0]}), .error_threshold_ff(error_threshold_ff),
		.skip_align_sequence_ff(skip_align_sequence_ff), .irq(irq));

	task automatic reg_write(input logic [11:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr_stb <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr_stb <= 1'b0;
	endtask

	// read data stands only in the cycle after the strobe edge
	task automatic reg_read(input logic [11:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd_stb <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd_stb <= 1'b0;
		#1 d = reg_rdata_ff;
	endtask

	// lock levels cross two sync flops and the flag register, so allow 6 edges
	task automatic lane_set(input logic l, input logic [23:0] c, input logic [4:0] k);
		@(posedge clk_sys);
		cmd_stb <= 1'b1;
		cmd_lane <= l;
		cmd_cnts <= c;
		cmd_locks <= k;
		@(posedge clk_sys);
		cmd_stb <= 1'b0;
		repeat (6) @(posedge clk_sys);
	endtask

	task automatic tally_and_finish;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	initial begin
		#(50 * 4000);
		mismatches++;
		tally_and_finish();
	end

	initial begin
		repeat (16) @(posedge clk_sys);
		sys_rst <= 1'b0;
		reg_read(SLLS_LANE2_OFS, rd);
		`CHK("lane2 reset", SLLS_FLAGS_RST, rd)
		reg_read(SLLS_LANE3_OFS, rd);
		`CHK("lane3 reset", SLLS_FLAGS_RST, rd)
		`CHK("threshold reset", SLLS_THRESH_RST, error_threshold_ff)
		reg_read(12'h07ff, rd);
		`CHK("unmapped read", SLLS_RD_ZERO, rd)
		reg_write(SLLS_THRESH_OFS, 8'h20);
		reg_read(SLLS_THRESH_OFS, rd);
		`CHK("threshold write", 8'h20, rd)
		foreach (rows[i]) begin
			lane_set(rows[i].lane, rows[i].cnts, rows[i].locks);
			reg_read(rows[i].lane ? SLLS_LANE3_OFS : SLLS_LANE2_OFS, rd);
			`CHK("lane flags", rows[i].flags, rd)
		end
		// writes to a status register must leave the flags alone
		reg_write(SLLS_LANE3_OFS, 8'h00);
		reg_read(SLLS_LANE3_OFS, rd);
		`CHK("status after write", 8'h55, rd)
		reg_write(SLLS_LANE2_OFS, 8'hff);
		reg_read(SLLS_LANE2_OFS, rd);
		`CHK("lane2 after write", 8'h21, rd)
		// with the skip setting on, only code group sync and error bits are used
		reg_write(SLLS_CTRL_OFS, 8'h01);
		lane_set(1'b1, 24'h00_0000, 5'h01);
		`CHK("skip setting", 1'b1, skip_align_sequence_ff)
		reg_read(SLLS_CTRL_OFS, rd);
		`CHK("skip readback", 8'h01, rd)
		reg_read(SLLS_LANE3_OFS, rd);
		`CHK("code group under skip", 8'h01, rd & 8'he1)
		reg_write(SLLS_CTRL_OFS, 8'h00);
		reg_write(SLLS_IRQ_STAT_OFS, 8'h0f);
		reg_read(SLLS_IRQ_STAT_OFS, rd);
		`CHK("irq status cleared", 8'h00, rd)
		// code group loss on lane 3 sets status bit 3
		lane_set(1'b1, 24'h00_0000, 5'h00);
		reg_write(SLLS_IRQ_MASK_OFS, 8'h04);
		#1 `CHK("irq masked", 1'b0, irq)
		reg_write(SLLS_IRQ_MASK_OFS, 8'h08);
		#1 `CHK("irq raised", 1'b1, irq)
		reg_read(SLLS_IRQ_MASK_OFS, rd);
		`CHK("irq mask readback", 8'h08, rd)
		reg_write(SLLS_IRQ_STAT_OFS, 8'h08);
		reg_read(SLLS_IRQ_STAT_OFS, rd);
		`CHK("irq status w1c", 8'h00, rd)
		`CHK("irq cleared", 1'b0, irq)
		// threshold 0: a zero count already meets it, so every error flag is set
		reg_write(SLLS_THRESH_OFS, 8'h00);
		// this clear lands in the very cycle the error events fire, so the set must win
		reg_write(SLLS_IRQ_STAT_OFS, 8'h0f);
		repeat (3) @(posedge clk_sys);
		reg_read(SLLS_LANE3_OFS, rd);
		`CHK("zero threshold", 8'he0, rd)
		reg_read(SLLS_IRQ_STAT_OFS, rd);
		`CHK("error irq status", 8'h03, rd)
		reg_write(SLLS_THRESH_OFS, 8'hff);
		lane_set(1'b0, 24'hff_fe00, 5'h00);
		reg_read(SLLS_LANE2_OFS, rd);
		`CHK("full threshold", 8'h80, rd)
		// a second reset in mid run must bring flags and threshold back
		@(posedge clk_sys);
		sys_rst <= 1'b1;
		repeat (3) @(posedge clk_sys);
		sys_rst <= 1'b0;
		reg_read(SLLS_LANE2_OFS, rd);
		`CHK("lane2 after mid reset", SLLS_FLAGS_RST, rd)
		`CHK("threshold after mid reset", SLLS_THRESH_RST, error_threshold_ff)
		tally_and_finish();
	end
endmodule

// *** common/slls_pkg.sv ***
// constants shared by the lane link status bank
package slls_pkg;
	localparam int SLLS_ADDR_W = 12;
	localparam int SLLS_DATA_W = 8;
	localparam int SLLS_CNT_W = 8;
	localparam int SLLS_NUM_LANES = 2;
	localparam int SLLS_FIRST_LANE = 2;
	localparam int SLLS_SYNC_W = 5;
	localparam int SLLS_IRQ_W = 2 * SLLS_NUM_LANES;

	localparam logic [SLLS_ADDR_W-1:0] SLLS_LANE2_OFS = 12'h4B2;
	localparam logic [SLLS_ADDR_W-1:0] SLLS_LANE3_OFS = 12'h4B3;
	localparam logic [SLLS_ADDR_W-1:0] SLLS_THRESH_OFS = 12'h4C0;
	localparam logic [SLLS_ADDR_W-1:0] SLLS_CTRL_OFS = 12'h4C1;
	localparam logic [SLLS_ADDR_W-1:0] SLLS_IRQ_STAT_OFS = 12'h4C2;
	localparam logic [SLLS_ADDR_W-1:0] SLLS_IRQ_MASK_OFS = 12'h4C3;

	localparam int SLLS_BIT_DISP = 7;
	localparam int SLLS_BIT_SYM = 6;
	localparam int SLLS_BIT_CTRL = 5;
	localparam int SLLS_BIT_DESKEW = 4;
	localparam int SLLS_BIT_ILAS = 3;
	localparam int SLLS_BIT_CKS = 2;
	localparam int SLLS_BIT_FRAME = 1;
	localparam int SLLS_BIT_CGS = 0;
	localparam int SLLS_BIT_SKIP = 0;

	localparam logic [SLLS_DATA_W-1:0] SLLS_FLAGS_RST = 8'h00;
	localparam logic [SLLS_CNT_W-1:0] SLLS_THRESH_RST = 8'hFF;
	localparam logic SLLS_SKIP_RST = 1'b0;
	localparam logic [SLLS_IRQ_W-1:0] SLLS_IRQ_RST = 4'h0;
	localparam logic [SLLS_DATA_W-1:0] SLLS_RD_ZERO = 8'h00;
	localparam logic [SLLS_SYNC_W-1:0] SLLS_SYNC_RST = 5'h00;
endpackage

// *** design/slls_lane.sv ***
// one lane: threshold compares and synchronised lock levels
`timescale 1ns/1ns
module slls_lane
	import slls_pkg::*;
#(
	parameter int CNT_W = SLLS_CNT_W
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [CNT_W-1:0] error_threshold,
	input wire logic [CNT_W-1:0] disp_cnt,
	input wire logic [CNT_W-1:0] sym_cnt,
	input wire logic [CNT_W-1:0] ctrl_cnt,
	input wire logic [SLLS_SYNC_W-1:0] lock_raw,
	output logic [SLLS_DATA_W-1:0] flags_ff
);
	logic [SLLS_SYNC_W-1:0] meta_ff;
	logic [SLLS_SYNC_W-1:0] sync_ff;

	// lock levels come from the lane receivers, outside this clock
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			meta_ff <= SLLS_SYNC_RST;
			sync_ff <= SLLS_SYNC_RST;
		end else begin
			meta_ff <= lock_raw;
			sync_ff <= meta_ff;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			flags_ff <= SLLS_FLAGS_RST; // R10
		end else begin
			flags_ff[SLLS_BIT_DISP] <= disp_cnt >= error_threshold; // R1
			flags_ff[SLLS_BIT_SYM] <= sym_cnt >= error_threshold; // R2
			flags_ff[SLLS_BIT_CTRL] <= ctrl_cnt >= error_threshold; // R3
			flags_ff[SLLS_BIT_DESKEW] <= sync_ff[SLLS_BIT_DESKEW]; // R4
			flags_ff[SLLS_BIT_ILAS] <= sync_ff[SLLS_BIT_ILAS]; // R5
			flags_ff[SLLS_BIT_CKS] <= sync_ff[SLLS_BIT_CKS]; // R6
			flags_ff[SLLS_BIT_FRAME] <= sync_ff[SLLS_BIT_FRAME]; // R7
			flags_ff[SLLS_BIT_CGS] <= sync_ff[SLLS_BIT_CGS]; // R8
		end
	end
endmodule

// *** design/slls_link_status.sv ***
// lane 2 and 3 link health registers with software port and interrupt
// What this block does
// R1: status bit 7 reads 1 while the lane's disparity error count is at or above the error threshold, else 0.
// R2: status bit 6 reads 1 while the lane's unknown symbol count is at or above the error threshold, else 0.
// R3: status bit 5 reads 1 while the lane's stray control character count is at or above the threshold, else 0.
// R4: status bit 4 reads 1 when the lane is deskewed and 0 when deskew failed.
// R5: status bit 3 reads 1 when initial lane alignment is achieved and 0 when it is lost.
// R6: status bit 2 reads 1 when the lane's configuration checksum is correct and 0 when it is not.
// R7: status bit 1 reads 1 while the lane holds frame sync and 0 when it is lost.
// R8: status bit 0 reads 1 while code group sync is held, whatever the alignment sequence setting.
// R9: software ignores bits 4 to 1 whenever skip_align_sequence is 1.
// R10: all lane status flags reset to 0, are read only, and writes leave them untouched.
`timescale 1ns/1ns
module slls_link_status
	import slls_pkg::*;
#(
	parameter int NUM_LANES = SLLS_NUM_LANES,
	parameter int CNT_W = SLLS_CNT_W
) (
	input wire logic clk_sys,
	input wire logic sys_rst,
	input wire logic [SLLS_ADDR_W-1:0] reg_addr,
	input wire logic [SLLS_DATA_W-1:0] reg_wdata,
	input wire logic reg_wr_stb,
	input wire logic reg_rd_stb,
	output logic [SLLS_DATA_W-1:0] reg_rdata_ff,
	input wire logic [NUM_LANES-1:0][CNT_W-1:0] disp_cnt,
	input wire logic [NUM_LANES-1:0][CNT_W-1:0] sym_cnt,
	input wire logic [NUM_LANES-1:0][CNT_W-1:0] ctrl_cnt,
	input wire logic [NUM_LANES-1:0] deskew_done,
	input wire logic [NUM_LANES-1:0] initial_align_ok,
	input wire logic [NUM_LANES-1:0] config_checksum_ok,
	input wire logic [NUM_LANES-1:0] frame_lock,
	input wire logic [NUM_LANES-1:0] codegroup_lock,
	output logic [CNT_W-1:0] error_threshold_ff,
	output logic skip_align_sequence_ff,
	output logic irq
);
	import slls_pkg::*;

	logic [NUM_LANES-1:0][SLLS_DATA_W-1:0] lane_flags;
	logic [NUM_LANES-1:0][SLLS_DATA_W-1:0] prev_flags_ff;
	logic [SLLS_IRQ_W-1:0] irq_stat_ff;
	logic [SLLS_IRQ_W-1:0] irq_mask_ff;
	logic [SLLS_IRQ_W-1:0] irq_event;
	logic [SLLS_IRQ_W-1:0] irq_clear;
	logic [SLLS_DATA_W-1:0] nxt_rdata;
	logic wr_thresh;
	logic wr_ctrl;
	logic wr_stat;
	logic wr_mask;

	// one instance per lane keeps the flag logic identical across lanes
	genvar gi;
	generate
		for (gi = 0; gi < NUM_LANES; gi++) begin : g_lane
			slls_lane #(
				.CNT_W(CNT_W)
			) u_lane (
				.clk_sys(clk_sys),
				.sys_rst(sys_rst),
				.error_threshold(error_threshold_ff),
				.disp_cnt(disp_cnt[gi]),
				.sym_cnt(sym_cnt[gi]),
				.ctrl_cnt(ctrl_cnt[gi]),
				.lock_raw({deskew_done[gi], initial_align_ok[gi], config_checksum_ok[gi],
					frame_lock[gi], codegroup_lock[gi]}),
				.flags_ff(lane_flags[gi])
			);

			// event: any error flag newly set, or code group lock newly lost
			assign irq_event[gi] = |(lane_flags[gi][SLLS_BIT_DISP:SLLS_BIT_CTRL]
				& ~prev_flags_ff[gi][SLLS_BIT_DISP:SLLS_BIT_CTRL]);
			assign irq_event[NUM_LANES+gi] = prev_flags_ff[gi][SLLS_BIT_CGS]
				& ~lane_flags[gi][SLLS_BIT_CGS];
		end
	endgenerate

	// write decode; lane status offsets are absent, so writes to them fall away
	assign wr_thresh = reg_wr_stb && (reg_addr == SLLS_THRESH_OFS);
	assign wr_ctrl = reg_wr_stb && (reg_addr == SLLS_CTRL_OFS);
	assign wr_stat = reg_wr_stb && (reg_addr == SLLS_IRQ_STAT_OFS);
	assign wr_mask = reg_wr_stb && (reg_addr == SLLS_IRQ_MASK_OFS);
	assign irq_clear = wr_stat ? reg_wdata[SLLS_IRQ_W-1:0] : SLLS_IRQ_RST;

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			error_threshold_ff <= SLLS_THRESH_RST;
		end else if (wr_thresh) begin
			error_threshold_ff <= reg_wdata[CNT_W-1:0];
		end
	end

	// the skip setting only tells software which flags to trust; flags keep running
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			skip_align_sequence_ff <= SLLS_SKIP_RST;
		end else if (wr_ctrl) begin
			skip_align_sequence_ff <= reg_wdata[SLLS_BIT_SKIP];
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			prev_flags_ff <= '0;
		end else begin
			prev_flags_ff <= lane_flags;
		end
	end

	// set beats clear so an event in the clearing cycle is kept
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_stat_ff <= SLLS_IRQ_RST;
		end else begin
			irq_stat_ff <= (irq_stat_ff & ~irq_clear) | irq_event;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			irq_mask_ff <= SLLS_IRQ_RST;
		end else if (wr_mask) begin
			irq_mask_ff <= reg_wdata[SLLS_IRQ_W-1:0];
		end
	end

	assign irq = |(irq_stat_ff & irq_mask_ff);

	// read mux; unmapped addresses read zero
	always_comb begin
		nxt_rdata = SLLS_RD_ZERO;
		case (reg_addr)
			SLLS_LANE2_OFS: begin
				nxt_rdata = lane_flags[0]; // R10
			end
			SLLS_LANE3_OFS: begin
				nxt_rdata = lane_flags[NUM_LANES-1];
			end
			SLLS_THRESH_OFS: begin
				nxt_rdata[CNT_W-1:0] = error_threshold_ff;
			end
			SLLS_CTRL_OFS: begin
				nxt_rdata[SLLS_BIT_SKIP] = skip_align_sequence_ff;
			end
			SLLS_IRQ_STAT_OFS: begin
				nxt_rdata[SLLS_IRQ_W-1:0] = irq_stat_ff;
			end
			SLLS_IRQ_MASK_OFS: begin
				nxt_rdata[SLLS_IRQ_W-1:0] = irq_mask_ff;
			end
			default: begin
				nxt_rdata = SLLS_RD_ZERO;
			end
		endcase
	end

	// data stands only in the cycle after the read strobe
	always_ff @(posedge clk_sys) begin
		if (sys_rst) begin
			reg_rdata_ff <= SLLS_RD_ZERO;
		end else if (reg_rd_stb) begin
			reg_rdata_ff <= nxt_rdata;
		end else begin
			reg_rdata_ff <= SLLS_RD_ZERO;
		end
	end

	// checks per lane
	generate
		for (gi = 0; gi < NUM_LANES; gi++) begin : g_chk
			disp_thresh_a: assert property ( // R1
				@(posedge clk_sys) disable iff (sys_rst)
				!$past(sys_rst) |->
				lane_flags[gi][SLLS_BIT_DISP] == ($past(disp_cnt[gi]) >= $past(error_threshold_ff))
			) else $error("disparity flag does not match count against threshold");

			sym_thresh_a: assert property ( // R2
				@(posedge clk_sys) disable iff (sys_rst)
				(!$past(sys_rst) && $past(sym_cnt[gi]) < $past(error_threshold_ff))
				|-> !lane_flags[gi][SLLS_BIT_SYM]
			) else $error("unknown symbol flag set below threshold");

			sym_reach_a: assert property ( // R2
				@(posedge clk_sys) disable iff (sys_rst)
				(sym_cnt[gi] >= error_threshold_ff) |=> lane_flags[gi][SLLS_BIT_SYM]
			) else $error("unknown symbol flag clear at threshold");

			ctrl_thresh_a: assert property ( // R3
				@(posedge clk_sys) disable iff (sys_rst)
				(ctrl_cnt[gi] >= error_threshold_ff) |=> lane_flags[gi][SLLS_BIT_CTRL]
			) else $error("stray control flag clear at threshold");

			ctrl_below_a: assert property ( // R3
				@(posedge clk_sys) disable iff (sys_rst)
				(ctrl_cnt[gi] < error_threshold_ff) ##1 !$past(sys_rst)
				|-> !lane_flags[gi][SLLS_BIT_CTRL]
			) else $error("stray control flag set below threshold");

			deskew_track_a: assert property ( // R4
				@(posedge clk_sys) disable iff (sys_rst)
				deskew_done[gi] [*3] |=> lane_flags[gi][SLLS_BIT_DESKEW]
			) else $error("deskew flag low after steady deskew");

			deskew_fail_a: assert property ( // R4
				@(posedge clk_sys) disable iff (sys_rst)
				!deskew_done[gi] [*3] |=> !lane_flags[gi][SLLS_BIT_DESKEW]
			) else $error("deskew flag high after deskew failure");

			align_track_a: assert property ( // R5
				@(posedge clk_sys) disable iff (sys_rst)
				$rose(initial_align_ok[gi]) ##1 initial_align_ok[gi] [*2]
				|=> lane_flags[gi][SLLS_BIT_ILAS]
			) else $error("alignment flag did not follow alignment");

			align_lost_a: assert property ( // R5
				@(posedge clk_sys) disable iff (sys_rst)
				!initial_align_ok[gi] [*3] |=> !lane_flags[gi][SLLS_BIT_ILAS]
			) else $error("alignment flag high after alignment loss");

			cks_track_a: assert property ( // R6
				@(posedge clk_sys) disable iff (sys_rst)
				config_checksum_ok[gi] [*3] |=> lane_flags[gi][SLLS_BIT_CKS]
			) else $error("checksum flag low with good checksum");

			cks_bad_a: assert property ( // R6
				@(posedge clk_sys) disable iff (sys_rst)
				!config_checksum_ok[gi] [*3] |=> !lane_flags[gi][SLLS_BIT_CKS]
			) else $error("checksum flag high with bad checksum");

			frame_track_a: assert property ( // R7
				@(posedge clk_sys) disable iff (sys_rst)
				frame_lock[gi] [*3] |=> lane_flags[gi][SLLS_BIT_FRAME]
			) else $error("frame flag low with frame sync held");

			frame_lost_a: assert property ( // R7
				@(posedge clk_sys) disable iff (sys_rst)
				!frame_lock[gi] [*3] |=> !lane_flags[gi][SLLS_BIT_FRAME]
			) else $error("frame flag high after frame sync lost");

			cgs_skip_a: assert property ( // R8
				@(posedge clk_sys) disable iff (sys_rst)
				(codegroup_lock[gi] && skip_align_sequence_ff) [*3]
				|=> lane_flags[gi][SLLS_BIT_CGS]
			) else $error("code group flag low while skip setting is on");

			cgs_lost_a: assert property ( // R8
				@(posedge clk_sys) disable iff (sys_rst)
				!codegroup_lock[gi] [*3] |=> !lane_flags[gi][SLLS_BIT_CGS]
			) else $error("code group flag high after lock lost");

			err_event_a: assert property (
				@(posedge clk_sys) disable iff (sys_rst)
				($rose(lane_flags[gi][SLLS_BIT_DISP]) || $rose(lane_flags[gi][SLLS_BIT_SYM])
					|| $rose(lane_flags[gi][SLLS_BIT_CTRL])) |=> irq_stat_ff[gi]
			) else $error("error flag rise did not set its status bit");

			cgs_event_a: assert property (
				@(posedge clk_sys) disable iff (sys_rst)
				$fell(lane_flags[gi][SLLS_BIT_CGS]) |=> irq_stat_ff[NUM_LANES+gi]
			) else $error("code group loss did not set its status bit");

			flags_reset_a: assert property ( // R10
				@(posedge clk_sys)
				$past(sys_rst) |-> lane_flags[gi] == SLLS_FLAGS_RST
			) else $error("lane flags not zero after reset");
		end
	endgenerate

	status_read_a: assert property ( // R10
		@(posedge clk_sys) disable iff (sys_rst)
		(reg_rd_stb && reg_addr == SLLS_LANE3_OFS)
		|=> reg_rdata_ff == $past(lane_flags[NUM_LANES-1])
	) else $error("lane 3 read does not return its flags");

	status_ro_a: assert property ( // R10
		@(posedge clk_sys) disable iff (sys_rst)
		(reg_wr_stb && reg_addr == SLLS_LANE2_OFS
			&& reg_wdata != lane_flags[0] && $stable(disp_cnt) && $stable(sym_cnt)
			&& $stable(ctrl_cnt) && $stable(error_threshold_ff) && !$past(sys_rst))
		|-> ##1 lane_flags[0][SLLS_BIT_DISP:SLLS_BIT_CTRL]
			== $past(lane_flags[0][SLLS_BIT_DISP:SLLS_BIT_CTRL])
	) else $error("write to lane status changed error flags");

	set_wins_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		(wr_stat && |(irq_event & reg_wdata[SLLS_IRQ_W-1:0]))
		|=> |(irq_stat_ff & $past(irq_event))
	) else $error("event lost in the clearing cycle");

	rdata_idle_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!reg_rd_stb |=> reg_rdata_ff == SLLS_RD_ZERO
	) else $error("read data outside read cycle");

	// register and interrupt checks
	thresh_write_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		wr_thresh |=> error_threshold_ff == $past(reg_wdata[CNT_W-1:0])
	) else $error("threshold write not taken");

	thresh_hold_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		!wr_thresh |=> $stable(error_threshold_ff)
	) else $error("threshold changed without a write");

	skip_write_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		wr_ctrl |=> skip_align_sequence_ff == $past(reg_wdata[SLLS_BIT_SKIP])
	) else $error("skip setting write not taken");

	mask_write_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		wr_mask |=> irq_mask_ff == $past(reg_wdata[SLLS_IRQ_W-1:0])
	) else $error("interrupt mask write not taken");

	stat_clear_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		(wr_stat && irq_event == SLLS_IRQ_RST)
		|=> (irq_stat_ff & $past(reg_wdata[SLLS_IRQ_W-1:0])) == SLLS_IRQ_RST
	) else $error("written one did not clear its status bit");

	lane2_read_a: assert property ( // R10
		@(posedge clk_sys) disable iff (sys_rst)
		(reg_rd_stb && reg_addr == SLLS_LANE2_OFS)
		|=> reg_rdata_ff == $past(lane_flags[0])
	) else $error("lane 2 read does not return its flags");

	thresh_read_a: assert property (
		@(posedge clk_sys) disable iff (sys_rst)
		(reg_rd_stb && reg_addr == SLLS_THRESH_OFS)
		|=> reg_rdata_ff[CNT_W-1:0] == $past(error_threshold_ff)
	) else $error("threshold read does not return the threshold");

	lane3_ro_a: assert property ( // R10
		@(posedge clk_sys) disable iff (sys_rst)
		(reg_wr_stb && reg_addr == SLLS_LANE3_OFS
			&& reg_wdata != lane_flags[NUM_LANES-1] && $stable(disp_cnt) && $stable(sym_cnt)
			&& $stable(ctrl_cnt) && $stable(error_threshold_ff) && !$past(sys_rst))
		|=> lane_flags[NUM_LANES-1][SLLS_BIT_DISP:SLLS_BIT_CTRL]
			== $past(lane_flags[NUM_LANES-1][SLLS_BIT_DISP:SLLS_BIT_CTRL])
	) else $error("write to lane 3 status changed error flags");

	regs_reset_a: assert property (
		@(posedge clk_sys)
		$past(sys_rst) |-> error_threshold_ff == SLLS_THRESH_RST && skip_align_sequence_ff == SLLS_SKIP_RST
			&& irq_stat_ff == SLLS_IRQ_RST && irq_mask_ff == SLLS_IRQ_RST && reg_rdata_ff == SLLS_RD_ZERO
	) else $error("registers not at reset values after reset");
endmodule
